// file: rcs_board.sv
`timescale 1ns/1ns
module rcs_board
    import rcs_pkg::*;
#(
    parameter logic [1:0] STRAPS = 2'b10
) (
    input  wire logic       clk_sys_i,
    input  wire logic       dev_n_i,
    input  wire logic       dev_oe_i,
    output logic            pin_n_o,
    output logic [1:0]      boot_mode_o
);
    logic pull_low;

    initial pull_low = 1'b0;

    // The pin has a pull-up; device and board both pull it low.
    assign pin_n_o = (dev_oe_i ? dev_n_i : 1'b1) & ~pull_low;
    // Straps never move during the run.
    assign boot_mode_o = STRAPS;

    // Holds the pin low for the given number of oscillator cycles.
    task automatic press(input int osc);
        @(posedge clk_sys_i);
        pull_low <= 1'b1;
        repeat (osc * 16) @(posedge clk_sys_i);
        pull_low <= 1'b0;
    endtask
endmodule

// file: rcs_map.svh
`ifndef RCS_MAP_SVH
`define RCS_MAP_SVH

// Clock rates and timing figures.
`define RCS_CLK_MHZ        50
`define RCS_OSC_DIV        16
`define RCS_POR_US         600
`define RCS_POR_CYC        (`RCS_POR_US * `RCS_CLK_MHZ)
`define RCS_WDOG_OSC       512
`define RCS_WARM_OSC       32
`define RCS_SETTLE_OSC     32
`define RCS_INTOSC_US      3
`define RCS_INTOSC_CYC     (`RCS_INTOSC_US * `RCS_CLK_MHZ)
`define RCS_LOCK_OSC       64
`define RCS_LOCK_INC       7'h02

// Register word offsets (byte addresses).
`define RCS_OFS_PLL        8'h00
`define RCS_OFS_CTRL       8'h04
`define RCS_OFS_STATUS     8'h08

// Control register fields.
`define RCS_CTRL_CDS_LO    0
`define RCS_CTRL_LSP_LO    2
`define RCS_CTRL_XO_LO     5
`define RCS_CTRL_XO_EN     7

// Status register fields.
`define RCS_ST_LOCK_BUSY   0
`define RCS_ST_LOCK_DONE   1
`define RCS_ST_BUS_VALID   2
`define RCS_ST_INTOSC_OK   3
`define RCS_ST_CAUSE_LO    4
`define RCS_ST_BOOT_LO     6

// Reset values.
`define RCS_RST_PLL        5'h00
`define RCS_RST_CDS        2'h0
`define RCS_RST_LSP        3'h2
`define RCS_RST_XO         2'h0

`endif

// file: rcs_pkg.sv
package rcs_pkg;

    typedef enum logic [2:0] {
        PH_POR, PH_WDOG, PH_EXT, PH_SETTLE, PH_RUN
    } rcs_phase_t;

    typedef enum logic [1:0] {
        CAUSE_POR, CAUSE_WDOG, CAUSE_WARM
    } rcs_cause_t;

    typedef enum logic [1:0] {
        BOOT_FLASH, BOOT_RAM, BOOT_SERIAL, BOOT_WAIT
    } rcs_boot_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } rcs_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } rcs_wb_rsp_t;

    typedef struct packed {
        logic [5:0] acc;
        logic       tick;
    } rcs_rate_state_t;

    typedef struct packed {
        rcs_phase_t  phase;
        logic [14:0] timer;
        logic [3:0]  osc_cnt;
        logic [7:0]  intosc_cnt;
        logic        intosc_ok;
        logic        pin_s1;
        logic        pin_s2;
        logic [1:0]  boot_s1;
        logic [1:0]  boot_s2;
        logic [5:0]  warm_cnt;
        logic [4:0]  pll_mult;
        logic [1:0]  div_sel;
        logic [2:0]  lsp_div;
        logic [1:0]  xo_div;
        logic        xo_en;
        logic        lock_busy;
        logic [9:0]  lock_cnt;
        logic        lock_done;
        rcs_cause_t  cause;
        rcs_boot_t   boot_mode;
        logic        boot_start;
        logic [2:0]  lsp_cnt;
        logic [1:0]  xo_cnt;
        logic        lsp_tick;
        logic        xo_tick;
        rcs_wb_rsp_t rsp;
    } rcs_state_t;

endpackage

// file: rcs_rate_gen.sv
`timescale 1ns/1ns
module rcs_rate_gen
    import rcs_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       reset_i,
    input  wire logic [6:0] inc_i,
    output logic            tick_o
);

    rcs_rate_state_t st;
    rcs_rate_state_t next_st;
    logic [6:0]      sum;

    // Phase accumulator: one tick per 64/inc_i clock cycles on average.
    always_comb begin
        sum          = {1'b0, st.acc} + inc_i;
        next_st      = st;
        next_st.acc  = sum[5:0];
        next_st.tick = sum[6];
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick_o = st.tick;

endmodule

// file: rcs_sequencer.sv
// Summary of operation
// - After power-on the device itself drives the reset pin low for 600 us.
// - A watchdog reset drives the reset pin low for 512 oscillator cycles.
// - Bus activity becomes valid 32 oscillator cycles after the pin rises.
// - After reset the boot straps are sampled and select the boot target.
// - A multiplier write starts the lock phase in the very next cycle.
// - During lock the system clock runs at half the oscillator clock.
// - When lock completes the system clock takes the newly written rate.
// - The system clock is the oscillator clock times half the multiplier (0 counts as 2), divided by 4, 2 or 1.
// - The low-speed divider resets to divide by four.
// - The internal oscillator is valid only after its 3 us start-up time.
// - At power-up the system clock is oscillator/4 and clock-out is /4.
// - Boot code may select an undivided clock; clock-out starts hidden.
//
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ns
`include "rcs_map.svh"
module rcs_sequencer
    import rcs_pkg::*;
#(
    parameter int POR_CYC  = `RCS_POR_CYC,
    parameter int LOCK_OSC = `RCS_LOCK_OSC
) (
    input  wire logic        clk_sys_i,
    input  wire logic        reset_i,
    input  wire rcs_wb_req_t wb_req_i,
    output rcs_wb_rsp_t      wb_rsp_o,
    input  wire logic        watchdog_reset_i,
    input  wire logic        reset_pin_n_i,
    output logic             reset_pin_n_o,
    output logic             reset_pin_oe_o,
    input  wire logic [1:0]  boot_mode_i,
    output logic             chip_reset_o,
    output logic             bus_valid_o,
    output logic             boot_start_o,
    output rcs_boot_t        boot_target_o,
    output logic             system_clock_out_o,
    output logic             low_speed_periph_clock_o,
    output logic             external_clock_output_o,
    output logic             int_osc_valid_o,
    output logic             lock_active_o,
    output logic             lock_done_o
);

    rcs_state_t  st;
    rcs_state_t  next_st;
    logic        osc_tick;
    logic        sys_tick;
    logic [6:0]  sys_inc;
    logic        wb_go;
    logic        wb_wr;
    logic [31:0] rd_val;

    ////////////////////////////////////////////////////////////////////////
    // System clock rate, in steps of clk_sys_i/64 per cycle.
    function automatic logic [6:0] rate_inc(input logic       busy,
                                            input logic [4:0] mult,
                                            input logic [1:0] dsel);
        logic [6:0] pf4;
        pf4 = (mult == 5'h00) ? 7'h04 : {1'b0, mult, 1'b0};
        if (busy) begin
            return `RCS_LOCK_INC;
        end
        unique case (dsel)
            2'h2:    return pf4 >> 1;
            2'h3:    return pf4;
            default: return pf4 >> 2;
        endcase
    endfunction

    function automatic logic [31:0] read_mux(input logic [7:0] adr,
                                             input rcs_state_t s);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (adr)
            `RCS_OFS_PLL:  v[4:0] = s.pll_mult;
            `RCS_OFS_CTRL: v[7:0] = {s.xo_en, s.xo_div, s.lsp_div, s.div_sel};
            `RCS_OFS_STATUS: begin
                v[`RCS_ST_LOCK_BUSY] = s.lock_busy;
                v[`RCS_ST_LOCK_DONE] = s.lock_done;
                v[`RCS_ST_BUS_VALID] = (s.phase == PH_RUN);
                v[`RCS_ST_INTOSC_OK] = s.intosc_ok;
                v[`RCS_ST_CAUSE_LO +: 2] = s.cause;
                v[`RCS_ST_BOOT_LO +: 2]  = s.boot_mode;
            end
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    assign osc_tick = (st.osc_cnt == 4'(`RCS_OSC_DIV - 1));
    assign sys_inc  = rate_inc(st.lock_busy, st.pll_mult, st.div_sel);
    assign wb_go    = wb_req_i.cyc && wb_req_i.stb && !st.rsp.ack;
    assign wb_wr    = wb_go && wb_req_i.we && wb_req_i.sel[0];
    assign rd_val   = read_mux(wb_req_i.adr, st);

    rcs_rate_gen u_rate (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .inc_i     (sys_inc),
        .tick_o    (sys_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st            = st;
        next_st.pin_s1     = reset_pin_n_i;
        next_st.pin_s2     = st.pin_s1;
        next_st.boot_s1    = boot_mode_i;
        next_st.boot_s2    = st.boot_s1;
        next_st.osc_cnt    = st.osc_cnt + 4'h1;
        next_st.boot_start = 1'b0;
        next_st.lsp_tick   = 1'b0;
        next_st.xo_tick    = 1'b0;
        if (!st.intosc_ok) begin
            next_st.intosc_cnt = st.intosc_cnt + 8'h01;
            if (st.intosc_cnt == 8'(`RCS_INTOSC_CYC - 1)) begin
                next_st.intosc_ok = 1'b1;
            end
        end
        unique case (st.phase)
            PH_POR: begin
                next_st.timer = st.timer + 15'h0001;
                if (st.timer == 15'(POR_CYC - 1)) begin
                    next_st.phase = PH_SETTLE;
                    next_st.timer = '0;
                end
            end
            PH_WDOG: begin
                if (osc_tick) begin
                    next_st.timer = st.timer + 15'h0001;
                    if (st.timer == 15'(`RCS_WDOG_OSC - 1)) begin
                        next_st.phase = PH_SETTLE;
                        next_st.timer = '0;
                    end
                end
            end
            PH_EXT: begin
                if (st.pin_s2) begin
                    next_st.phase = PH_SETTLE;
                    next_st.timer = '0;
                end
            end
            PH_SETTLE: begin
                if (!st.pin_s2) begin
                    next_st.timer = '0;
                end else if (osc_tick) begin
                    next_st.timer = st.timer + 15'h0001;
                    if (st.timer == 15'(`RCS_SETTLE_OSC - 1)) begin
                        next_st.phase      = PH_RUN;
                        next_st.boot_mode  = rcs_boot_t'(st.boot_s2);
                        next_st.boot_start = 1'b1;
                    end
                end
            end
            PH_RUN: begin
                if (watchdog_reset_i) begin
                    next_st.phase = PH_WDOG;
                    next_st.cause = CAUSE_WDOG;
                    next_st.timer = '0;
                end else if (st.pin_s2) begin
                    next_st.warm_cnt = '0;
                end else if (osc_tick) begin
                    next_st.warm_cnt = st.warm_cnt + 6'h01;
                    if (st.warm_cnt == 6'(`RCS_WARM_OSC - 1)) begin
                        next_st.phase = PH_EXT;
                        next_st.cause = CAUSE_WARM;
                    end
                end
            end
            default: ;
        endcase
        // Clock dividers run from the system clock enable.
        if (sys_tick) begin
            next_st.lsp_cnt = st.lsp_cnt + 3'h1;
            if (st.lsp_div == 3'h0 ||
                st.lsp_cnt >= 3'({st.lsp_div, 1'b0} - 4'h1)) begin
                next_st.lsp_cnt  = '0;
                next_st.lsp_tick = 1'b1;
            end
            next_st.xo_cnt = st.xo_cnt + 2'h1;
            if ((st.xo_div == 2'h0 && st.xo_cnt == 2'h3) ||
                (st.xo_div == 2'h1 && st.xo_cnt[0]) || st.xo_div[1]) begin
                next_st.xo_cnt  = '0;
                next_st.xo_tick = st.xo_en;
            end
        end
        // PLL lock phase.
        if (st.lock_busy && osc_tick) begin
            next_st.lock_cnt = st.lock_cnt + 10'h001;
            if (st.lock_cnt == 10'(LOCK_OSC - 1)) begin
                next_st.lock_busy = 1'b0;
                next_st.lock_done = 1'b1;
            end
        end
        // Register bus.
        next_st.rsp.ack = wb_go;
        if (wb_go) begin
            next_st.rsp.dat = rd_val;
        end
        if (wb_wr && st.phase == PH_RUN) begin
            unique case (wb_req_i.adr)
                `RCS_OFS_PLL: begin
                    next_st.pll_mult  = wb_req_i.dat[4:0];
                    next_st.lock_busy = 1'b1;
                    next_st.lock_done = 1'b0;
                    next_st.lock_cnt  = '0;
                end
                `RCS_OFS_CTRL: begin
                    next_st.div_sel = wb_req_i.dat[`RCS_CTRL_CDS_LO +: 2];
                    next_st.lsp_div = wb_req_i.dat[`RCS_CTRL_LSP_LO +: 3];
                    next_st.xo_div  = wb_req_i.dat[`RCS_CTRL_XO_LO +: 2];
                    next_st.xo_en   = wb_req_i.dat[`RCS_CTRL_XO_EN];
                end
                default: ;
            endcase
        end
        // Any reset phase returns the clock settings to their defaults.
        if (st.phase inside {PH_POR, PH_WDOG, PH_EXT}) begin
            next_st.pll_mult  = `RCS_RST_PLL;
            next_st.div_sel   = `RCS_RST_CDS;
            next_st.lsp_div   = `RCS_RST_LSP;
            next_st.xo_div    = `RCS_RST_XO;
            next_st.xo_en     = 1'b0;
            next_st.lock_busy = 1'b0;
            next_st.lock_done = 1'b0;
            next_st.warm_cnt  = '0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            st         <= '0;
            st.phase   <= PH_POR;
            st.pin_s1  <= 1'b1;
            st.pin_s2  <= 1'b1;
            st.lsp_div <= `RCS_RST_LSP;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign wb_rsp_o                 = st.rsp;
    assign reset_pin_n_o            = 1'b0;
    assign reset_pin_oe_o           = st.phase inside {PH_POR, PH_WDOG};
    assign chip_reset_o             = (st.phase != PH_RUN);
    assign bus_valid_o              = (st.phase == PH_RUN);
    assign boot_start_o             = st.boot_start;
    assign boot_target_o            = st.boot_mode;
    assign system_clock_out_o       = sys_tick;
    assign low_speed_periph_clock_o = st.lsp_tick;
    assign external_clock_output_o  = st.xo_tick;
    assign int_osc_valid_o          = st.intosc_ok;
    assign lock_active_o            = st.lock_busy;
    assign lock_done_o              = st.lock_done;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    logic [14:0] drive_len;
    always_ff @(posedge clk_sys_i) begin
        if (reset_i || !reset_pin_oe_o) begin
            drive_len <= '0;
        end else begin
            drive_len <= drive_len + 15'h0001;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    por_pin_drive_a: assert property (
        $fell(reset_i) |-> reset_pin_oe_o [*8])
        else $error("reset pin not driven after power-on");
    por_length_a: assert property (
        $fell(reset_pin_oe_o) && st.cause == CAUSE_POR
        |-> drive_len == 15'(POR_CYC))
        else $error("power-on pulse has wrong length");
    wdog_length_a: assert property (
        $fell(reset_pin_oe_o) && st.cause == CAUSE_WDOG
        |-> drive_len > 15'h1ff0 && drive_len <= 15'h2001)
        else $error("watchdog pulse has wrong length");
    settle_wait_a: assert property (
        $fell(reset_pin_oe_o) |-> !bus_valid_o [*8])
        else $error("bus valid too soon after release");
    warm_filter_a: assert property (
        st.phase == PH_RUN && st.warm_cnt < 6'h1f && !watchdog_reset_i
        |=> st.phase == PH_RUN)
        else $error("short pin pulse caused a warm reset");
    lock_start_a: assert property (
        wb_wr && wb_req_i.adr == `RCS_OFS_PLL && bus_valid_o
        |=> lock_active_o && !lock_done_o)
        else $error("lock did not start after multiplier write");
    lock_rate_a: assert property (
        lock_active_o && $past(lock_active_o) && system_clock_out_o
        |=> (!system_clock_out_o || !lock_active_o) [*8])
        else $error("system clock not at half rate during lock");
    lock_end_a: assert property (
        $fell(lock_active_o) && bus_valid_o
        |-> lock_done_o
            && sys_inc == rate_inc(1'b0, st.pll_mult, st.div_sel))
        else $error("new rate not applied after lock");
    boot_sample_a: assert property (
        boot_start_o |-> bus_valid_o && $past(chip_reset_o))
        else $error("boot sampling outside reset release");
    intosc_wait_a: assert property (
        $fell(reset_i) |-> !int_osc_valid_o [*8])
        else $error("internal oscillator valid too early");
    defaults_a: assert property (
        st.phase == PH_POR |=> st.div_sel == 2'h0 && st.lsp_div == 3'h2
                               && !st.xo_en)
        else $error("clock settings not at reset values");

    cover_wdog_c: cover property (
        st.phase == PH_WDOG ##1 st.phase == PH_SETTLE);
    cover_warm_c: cover property (
        st.phase == PH_EXT ##1 st.phase == PH_SETTLE);
    cover_lock_c: cover property ($fell(lock_active_o) && lock_done_o);

endmodule

// file: testbench.sv
`timescale 1ns/1ns
module testbench
    import rcs_pkg::*;
;
    localparam int POR  = 200;
    localparam int LOCK = 4;

    logic        clk_sys_i;
    logic        reset_i;
    rcs_wb_req_t req;
    rcs_wb_rsp_t rsp;
    logic        wdog;
    logic        pin_n;
    logic        dev_n;
    logic        oe;
    logic [1:0]  straps;
    logic        chip_reset_o;
    logic        bus_valid_o;
    logic        boot_start_o;
    rcs_boot_t   boot_target_o;
    logic        system_clock_out_o;
    logic        lsp_o;
    logic        xo_o;
    logic        int_osc_valid_o;
    logic        lock_active_o;
    logic        lock_done_o;
    int          mismatches;
    int          checks;
    logic [31:0] q;
    int          n;
    int          sp;
    int          lp;
    int          xp;

    rcs_sequencer #(.POR_CYC(POR), .LOCK_OSC(LOCK)) dut (
        .clk_sys_i               (clk_sys_i),
        .reset_i                 (reset_i),
        .wb_req_i                (req),
        .wb_rsp_o                (rsp),
        .watchdog_reset_i        (wdog),
        .reset_pin_n_i           (pin_n),
        .reset_pin_n_o           (dev_n),
        .reset_pin_oe_o          (oe),
        .boot_mode_i             (straps),
        .chip_reset_o            (chip_reset_o),
        .bus_valid_o             (bus_valid_o),
        .boot_start_o            (boot_start_o),
        .boot_target_o           (boot_target_o),
        .system_clock_out_o      (system_clock_out_o),
        .low_speed_periph_clock_o(lsp_o),
        .external_clock_output_o (xo_o),
        .int_osc_valid_o         (int_osc_valid_o),
        .lock_active_o           (lock_active_o),
        .lock_done_o             (lock_done_o)
    );

    rcs_board #(.STRAPS(2'b10)) board (
        .clk_sys_i  (clk_sys_i),
        .dev_n_i    (dev_n),
        .dev_oe_i   (oe),
        .pin_n_o    (pin_n),
        .boot_mode_o(straps)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check_val(input string nm, input logic [31:0] e,
                             input logic [31:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic check_near(input string nm, input int e, input int g,
                              input int tol);
        checks++;
        if (g < e - tol || g > e + tol) begin
            mismatches++;
            $display("mismatch %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    // One classic Wishbone cycle; data is taken at the acknowledging edge.
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        int k;
        @(posedge clk_sys_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
        k = 0;
        do begin
            @(posedge clk_sys_i);
            k++;
        end while (rsp.ack !== 1'b1 && k < 100);
        check_val("ack", 1, {31'h0, rsp.ack});
        r = rsp.dat;
        req <= '0;
    endtask

    task automatic count(input int len, output int s, output int l,
                         output int x);
        s = 0;
        l = 0;
        x = 0;
        repeat (len) begin
            @(negedge clk_sys_i);
            s += (system_clock_out_o === 1'b1);
            l += (lsp_o === 1'b1);
            x += (xo_o === 1'b1);
        end
    endtask

    task automatic wait_oe(output int k);
        k = 0;
        while (oe === 1'b1 && k < 20000) begin
            k++;
            @(negedge clk_sys_i);
        end
    endtask

    // Counts cycles until the bus opens and checks the boot pulse there.
    task automatic wait_bus(output int k);
        k = 0;
        while (bus_valid_o !== 1'b1 && k < 2000) begin
            k++;
            @(negedge clk_sys_i);
        end
        check_val("boot_start", 1, boot_start_o);
        check_val("boot_target", 2, {30'h0, boot_target_o});
    endtask

    task automatic pll(input logic [31:0] m, input int e);
        int dur;
        int s;
        int l;
        int x;
        logic [31:0] r;
        wb(1'b1, 8'h00, m, r);
        @(negedge clk_sys_i);
        check_val("lock_active", 1, lock_active_o);
        dur = 0;
        s = 0;
        while (lock_active_o === 1'b1 && dur < 1000) begin
            dur++;
            s += (system_clock_out_o === 1'b1);
            @(negedge clk_sys_i);
        end
        check_near("lock_len", LOCK * 16, dur, 18);
        check_near("lock_rate", dur / 32, s, 1);
        check_val("lock_done", 1, lock_done_o);
        count(640, s, l, x);
        check_near("pll_rate", e, s, 1);
        check_near("pll_lsp", e / 4, l, 1);
        check_near("pll_xo", e / 4, x, 1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    initial begin
        #(40000 * 20);
        mismatches++;
        results();
    end

    initial begin
        reset_i = 1'b1;
        req = '0;
        wdog = 1'b0;
        mismatches = 0;
        checks = 0;
        repeat (3) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        @(negedge clk_sys_i);
        check_val("intosc_early", 0, int_osc_valid_o);
        wait_oe(n);
        check_near("por_len", POR, n, 2);
        check_val("intosc_late", 1, int_osc_valid_o);
        wait_bus(n);
        check_near("settle", 512, n, 20);
        wb(1'b0, 8'h08, 32'h0, q);
        check_val("cause_por", 0, (q >> 4) & 32'h3);
        wb(1'b0, 8'h04, 32'h0, q);
        check_val("ctrl_reset", 32'h08, q);
        wb(1'b0, 8'h0c, 32'h0, q);
        check_val("unmapped", 0, q);
        count(2560, sp, lp, xp);
        check_near("sys_rate", 40, sp, 1);
        check_near("lsp_rate", 10, lp, 1);
        check_val("xo_hidden", 0, xp);
        wb(1'b1, 8'h04, 32'h8b, q);
        pll(32'h04, 80);
        pll(32'h08, 160);
        wb(1'b1, 8'h04, 32'haa, q);
        count(640, sp, lp, xp);
        check_near("half_rate", 80, sp, 1);
        check_near("half_lsp", 20, lp, 1);
        check_near("half_xo", 40, xp, 1);
        @(posedge clk_sys_i);
        wdog <= 1'b1;
        @(posedge clk_sys_i);
        wdog <= 1'b0;
        @(negedge clk_sys_i);
        check_val("wdog_reset", 1, chip_reset_o);
        wait_oe(n);
        check_near("wdog_len", 512 * 16, n, 20);
        wait_bus(n);
        check_near("wdog_settle", 512, n, 20);
        wb(1'b0, 8'h08, 32'h0, q);
        check_val("cause_wdog", 1, (q >> 4) & 32'h3);
        board.press(20);
        repeat (20) @(negedge clk_sys_i);
        check_val("short_press", 0, chip_reset_o);
        board.press(40);
        @(negedge clk_sys_i);
        check_val("warm_reset", 1, chip_reset_o);
        wait_bus(n);
        check_near("warm_settle", 512, n, 20);
        wb(1'b0, 8'h08, 32'h0, q);
        check_val("cause_warm", 2, (q >> 4) & 32'h3);
        results();
    end
endmodule
